// ---- rtl/scs_smbus_slave.sv ----
// Purpose: SMBus slave port to the configuration bytes, with APB view
// Assumes: scl/sda come from another domain and are synchronised here
// Notes: sda is open drain; sda_oe high pulls the line low
//
// Overview of operation
// [RULE_01] behave as an SMBus 2.0 slave on I2C-style signalling
// [RULE_02] accept byte write, byte read, block write and block read
// [RULE_03] block bytes move in ascending offset order, MSB first
// [RULE_04] a stop after any whole byte ends a block cleanly
// [RULE_05] byte transactions touch only the byte selected by the offset
// [RULE_06] each written byte takes effect at the rising edge of its ack
// [RULE_07] starting an EEPROM write copies the current registers into it
// [RULE_08] master sends no write data while EEPROM programming runs
// [RULE_09] reads are served normally during EEPROM programming
// [RULE_10] programming-in-progress flag shows in byte 24 bit 7
// [RULE_11] slave address is 11010 plus two low bits, default 0 and 1
// [RULE_12] low address bits come from byte 10 fields [1:0] and [3:2]
// [RULE_13] command bit 7 low means block, high means single byte
// [RULE_14] command bits 6..0 give the starting byte offset
// [RULE_15] byte write: address, command, data, each acked, then stop
// [RULE_16] byte read: command, repeated start, one byte, master ack, stop; the code answers a master ack by sending the next byte
// [RULE_17] block write: command, count N, then N acked data bytes
// [RULE_18] master writes byte 0 only with 0000 0001
// [RULE_19] all configuration bytes load their defaults at reset
// [RULE_20] ack is a low bit, not-ack a high bit in the ack slot
// [RULE_21] byte 0 is read only and returned only by byte read
// [RULE_22] every other byte is writable and readable
// [RULE_23] block read: count then bytes, master nacks the last one
module scs_smbus_slave
  import scs_pkg::*;
#(
  parameter int unsigned EE_PROG_CYCLES = 20000
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // smbus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output scs_pad_s sda_pad,
  // configuration and eeprom image
  output scs_cfg_t cfg_bytes,
  output scs_cfg_t ee_image,
  output logic eeprom_write_in_progress
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce) begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  // [RULE_01] start and stop
  assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ----------------------------------------
  // state declarations
  // ----------------------------------------
  scs_state_e st_q, st_d;
  scs_stage_e stage_q, stage_d;
  logic [7:0] sh_q, sh_d;
  logic [2:0] bit_q, bit_d;
  logic done_q, done_d;
  logic ack_q, ack_d;
  logic rd_q, rd_d;
  logic single_q, single_d;
  logic [6:0] ptr_q, ptr_d;
  logic [7:0] cnt_q, cnt_d;
  logic oe_q, oe_d;
  logic commit;
  logic ee_go_smb;

  scs_cfg_t cfg_q, cfg_d;
  scs_cfg_t img_q, img_d;
  logic eip_q, eip_d;
  logic [23:0] tmr_q, tmr_d;
  logic ee_go;

  logic en_q, en_d;
  logic ee_req_q, ee_req_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  logic [6:0] my_addr;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic ptr_ok;

  // [RULE_11] fixed upper bits
  // [RULE_12] low bits from byte 10
  assign my_addr = {ADDR_FIXED,
                    cfg_q[BYTE_ADDR_CFG][CFG_HIGH_LSB],
                    cfg_q[BYTE_ADDR_CFG][CFG_LOW_LSB]};
  assign rx_byte = {sh_q[6:0], sda_s_q};
  assign ptr_ok = ptr_q < NUM_BYTES_B[6:0];

  // ----------------------------------------
  // outgoing byte selection
  // ----------------------------------------
  always_comb begin
    tx_byte = 8'h00;
    if (stage_q == SG_COUNT) begin
      // [RULE_23] block read count
      if (ptr_ok) begin
        tx_byte = NUM_BYTES_B - {1'b0, ptr_q};
      end
    end else if (ptr_ok) begin
      tx_byte = cfg_q[ptr_q];
      if (ptr_q == BYTE_ID) begin
        // [RULE_21] id only by byte read
        tx_byte = single_q ? ID_BYTE : 8'h00;
      end
      if (ptr_q == BYTE_STATUS) begin
        // [RULE_10] status flag overlay
        tx_byte[EIP_BIT] = eip_q;
      end
    end
  end

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    stage_d = stage_q;
    sh_d = sh_q;
    bit_d = bit_q;
    done_d = done_q;
    ack_d = ack_q;
    rd_d = rd_q;
    single_d = single_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    oe_d = oe_q;
    commit = 1'b0;
    if (bus_start) begin
      // repeated start keeps the offset from the command
      st_d = ST_RX;
      stage_d = SG_ADDR;
      bit_d = 3'd0;
      done_d = 1'b0;
      oe_d = 1'b0;
    end else if (bus_stop) begin
      // [RULE_04] early stop, bytes kept
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          oe_d = 1'b0;
        end
        ST_RX: begin
          if (scl_rise && !done_q) begin
            sh_d = rx_byte;
            bit_d = bit_q + 3'd1;
            if (bit_q == 3'd7) begin
              done_d = 1'b1;
              // [RULE_15] slave acks command and count always, address and data only when accepted
              case (stage_q)
                SG_ADDR: begin
                  ack_d = en_q && (rx_byte[7:1] == my_addr);
                  rd_d = rx_byte[0];
                end
                SG_CMD: ack_d = 1'b1;
                SG_COUNT: ack_d = 1'b1;
                // [RULE_08] data refused during programming
                SG_DATA: ack_d = !eip_q && (cnt_q != 8'h00);
                default: ack_d = 1'b0;
              endcase
            end
          end else if (scl_fall && done_q) begin
            done_d = 1'b0;
            // [RULE_20] ack low, nack released
            if (ack_q) begin
              st_d = ST_ACK;
              oe_d = 1'b1;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_rise) begin
            case (stage_q)
              SG_ADDR: begin
                if (rd_q) begin
                  stage_d = single_q ? SG_DATA : SG_COUNT;
                end else begin
                  stage_d = SG_CMD;
                end
              end
              SG_CMD: begin
                // [RULE_13] block or single
                single_d = sh_q[CMD_SINGLE_BIT];
                // [RULE_14] start offset
                ptr_d = sh_q[6:0];
                // [RULE_05] single write is one byte
                cnt_d = 8'h01;
                stage_d = sh_q[CMD_SINGLE_BIT] ? SG_DATA : SG_COUNT;
              end
              SG_COUNT: begin
                // [RULE_17] byte count N
                cnt_d = sh_q;
                stage_d = SG_DATA;
              end
              default: begin
                // [RULE_06] write at ack rise
                commit = 1'b1;
                // [RULE_03] ascending offsets
                ptr_d = ptr_q + 7'd1;
                cnt_d = cnt_q - 8'h01;
              end
            endcase
          end else if (scl_fall) begin
            bit_d = 3'd0;
            if (rd_q && stage_q != SG_CMD) begin
              // [RULE_16] slave drives the read byte
              st_d = ST_TX;
              sh_d = tx_byte;
              oe_d = ~tx_byte[7];
            end else begin
              st_d = ST_RX;
              oe_d = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_q == 3'd7) begin
              st_d = ST_MACK;
              oe_d = 1'b0;
            end else begin
              // [RULE_03] msb first
              bit_d = bit_q + 3'd1;
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            // [RULE_23] master ack continues
            ack_d = !sda_s_q;
            if (!sda_s_q) begin
              if (stage_q == SG_COUNT) begin
                stage_d = SG_DATA;
              end else begin
                ptr_d = ptr_q + 7'd1;
              end
            end
          end else if (scl_fall) begin
            bit_d = 3'd0;
            if (ack_q) begin
              st_d = ST_TX;
              sh_d = tx_byte;
              oe_d = ~tx_byte[7];
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // [RULE_02] byte and block transfers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      stage_q <= SG_ADDR;
      sh_q <= 8'h00;
      bit_q <= 3'd0;
      done_q <= 1'b0;
      ack_q <= 1'b0;
      rd_q <= 1'b0;
      single_q <= 1'b0;
      ptr_q <= 7'h00;
      cnt_q <= 8'h00;
      oe_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      stage_q <= stage_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      done_q <= done_d;
      ack_q <= ack_d;
      rd_q <= rd_d;
      single_q <= single_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      oe_q <= oe_d;
    end
  end

  // ----------------------------------------
  // configuration bytes and eeprom cycle
  // ----------------------------------------
  assign ee_go_smb = commit && ptr_q == BYTE_EE_CTRL && sh_q[EE_WRITE_BIT];
  assign ee_go = (ee_go_smb || ee_req_q) && !eip_q;

  always_comb begin
    cfg_d = cfg_q;
    img_d = img_q;
    eip_d = eip_q;
    tmr_d = tmr_q;
    // [RULE_22] writable bytes, offsets past the map ignored
    // [RULE_21] byte 0 never written
    if (commit && ptr_ok && ptr_q != BYTE_ID) begin
      cfg_d[ptr_q] = sh_q;
    end
    if (ee_go) begin
      // [RULE_07] snapshot before this byte lands
      img_d = cfg_q;
      eip_d = 1'b1;
      tmr_d = 24'(EE_PROG_CYCLES);
    end else if (eip_q) begin
      // [RULE_09] reads are not gated here
      if (tmr_q <= 24'h000001) begin
        eip_d = 1'b0;
        tmr_d = 24'h000000;
      end else begin
        tmr_d = tmr_q - 24'h000001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // [RULE_19] power-up defaults
      cfg_q <= '0;
      cfg_q[BYTE_ADDR_CFG] <= DEF_ADDR_CFG;
      img_q <= '0;
      eip_q <= 1'b0;
      tmr_q <= 24'h000000;
    end else if (ce) begin
      cfg_q <= cfg_d;
      img_q <= img_d;
      eip_q <= eip_d;
      tmr_q <= tmr_d;
    end
  end

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  logic cfg_hit;
  logic [4:0] cfg_idx;
  assign cfg_idx = paddr[6:2];
  assign cfg_hit = paddr[11:7] == ADDR_CFG_BASE[11:7] && paddr[1:0] == 2'b00
                   && cfg_idx < NUM_BYTES_B[4:0];

  always_comb begin
    en_d = en_q;
    ee_req_d = 1'b0;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    // pready answers in the access phase after setup
    pready_d = psel && !penable;
    if (psel && !penable) begin
      prdata_d = 32'h00000000;
      if (paddr == ADDR_CTRL) begin
        prdata_d[CTRL_EN_BIT] = en_q;
      end else if (paddr == ADDR_STATUS) begin
        prdata_d[STAT_EIP_BIT] = eip_q;
        prdata_d[STAT_BUSY_BIT] = st_q != ST_IDLE;
        prdata_d[STAT_READ_BIT] = rd_q;
      end else if (cfg_hit) begin
        prdata_d[7:0] = cfg_q[cfg_idx];
      end else begin
        pslverr_d = 1'b1;
      end
    end
    if (psel && penable && pready_q) begin
      pslverr_d = 1'b0;
      if (pwrite && paddr == ADDR_CTRL) begin
        en_d = pwdata[CTRL_EN_BIT];
        ee_req_d = pwdata[CTRL_EE_BIT];
      end
    end else begin
      pslverr_d = pslverr_d | (pslverr_q & psel & penable);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b1;
      ee_req_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      en_q <= en_d;
      ee_req_q <= ee_req_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sda_pad.sda_o = 1'b0;
  assign sda_pad.sda_oe = oe_q;
  assign cfg_bytes = cfg_q;
  assign ee_image = img_q;
  assign eeprom_write_in_progress = eip_q;

endmodule

// ---- pkg/scs_pkg.sv ----
// Purpose: shared constants and types of the configuration port
// Assumes: 27 configuration bytes, APB register view
// Notes: the revision nibble of byte 0 is an arbitrary value
package scs_pkg;

  localparam int NUM_BYTES = 27;
  localparam logic [7:0] NUM_BYTES_B = 8'h1B;

  // ----------------------------------------
  // configuration byte map
  // ----------------------------------------
  localparam logic [6:0] BYTE_ID = 7'h00;
  localparam int BYTE_ADDR_CFG = 10;
  localparam logic [6:0] BYTE_STATUS = 7'h18;
  localparam logic [6:0] BYTE_EE_CTRL = 7'h1A;
  localparam int EIP_BIT = 7;
  localparam int EE_WRITE_BIT = 7;
  localparam int CFG_LOW_LSB = 0;
  localparam int CFG_HIGH_LSB = 2;
  localparam int CMD_SINGLE_BIT = 7;
  localparam logic [4:0] ADDR_FIXED = 5'h1A;
  // vendor nibble 0001, revision nibble arbitrary
  localparam logic [7:0] ID_BYTE = 8'h01;
  localparam logic [7:0] DEF_ADDR_CFG = 8'h01;

  // ----------------------------------------
  // APB register map
  // ----------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CFG_BASE = 12'h100;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_EE_BIT = 1;
  localparam int STAT_EIP_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_READ_BIT = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_MACK = 3'b100
  } scs_state_e;

  typedef enum logic [1:0] {
    SG_ADDR  = 2'b00,
    SG_CMD   = 2'b01,
    SG_COUNT = 2'b10,
    SG_DATA  = 2'b11
  } scs_stage_e;

  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } scs_pad_s;

  typedef logic [NUM_BYTES-1:0][7:0] scs_cfg_t;

endpackage

// ---- bench/scs_host_model.sv ----
// Purpose: behavioural smbus host for the configuration port
// Assumes: open-drain data line with pull-up, 48 ns bit period
// Notes: scl stands high between frames, as a released line would
module scs_host_model (
  // bus pins
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ----
  // bit level
  // ----
  // ack as low bit
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #12;
    scl = 1'b1;
    #12;
    r = sda;
    #12;
    scl = 1'b0;
    #12;
  endtask

  task automatic start();
    sda_low = 1'b0;
    #12;
    scl = 1'b1;
    #12;
    sda_low = 1'b1;
    #12;
    scl = 1'b0;
    #12;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #12;
    scl = 1'b1;
    #12;
    sda_low = 1'b0;
    #24;
  endtask

  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack);
  endtask
endmodule

// ---- bench/scs_checker.sv ----
// Purpose: concurrent checks on the configuration port pins
// Assumes: smbus phases outlast the input synchroniser lag
// Notes: attached by bind to every port instance
module scs_checker
  import scs_pkg::*;
#(
  parameter int unsigned EE_PROG_CYCLES = 20000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // smbus and state
  input wire logic scl_i,
  input wire scs_pad_s sda_pad,
  input wire scs_cfg_t cfg_bytes,
  input wire scs_cfg_t ee_image,
  input wire logic eeprom_write_in_progress
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [31:0] eip_cnt_q, eip_cnt_d;
  always_comb eip_cnt_d = eeprom_write_in_progress ? eip_cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) eip_cnt_q <= 32'h0;
    else eip_cnt_q <= eip_cnt_d;
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ee_start;
    $rose(eeprom_write_in_progress);
  endsequence

  property p_ready;
    s_setup |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_open_drain;
    sda_pad.sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  property p_drive_low_phase;
    $changed(sda_pad.sda_oe) |-> !$past(scl_i);
  endproperty
  a_drive_low_phase: assert property (p_drive_low_phase) else $error("sda moved, scl high");
  property p_write_at_ack;
    !$stable(cfg_bytes) |-> $past(scl_i) && $past(sda_pad.sda_oe);
  endproperty
  a_write_at_ack: assert property (p_write_at_ack) else $error("write off ack");
  property p_id_ro;
    cfg_bytes[0] == 8'h00;
  endproperty
  a_id_ro: assert property (p_id_ro) else $error("byte 0 changed");
  property p_ee_copy;
    s_ee_start |-> ee_image[25:0] == $past(cfg_bytes[25:0]);
  endproperty
  a_ee_copy: assert property (p_ee_copy) else $error("image not copied");
  property p_ee_hold;
    !$stable(ee_image) |-> s_ee_start;
  endproperty
  a_ee_hold: assert property (p_ee_hold) else $error("image moved");
  property p_no_write_busy;
    eeprom_write_in_progress && $past(eeprom_write_in_progress) |-> $stable(cfg_bytes);
  endproperty
  a_no_write_busy: assert property (p_no_write_busy) else $error("write while busy");
  property p_busy_len;
    $fell(eeprom_write_in_progress) |-> eip_cnt_q == EE_PROG_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
endmodule

bind scs_smbus_slave scs_checker #(.EE_PROG_CYCLES(EE_PROG_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .scl_i(scl_i), .sda_pad(sda_pad), .cfg_bytes(cfg_bytes),
  .ee_image(ee_image), .eeprom_write_in_progress(eeprom_write_in_progress)
);

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the smbus configuration port
// Assumes: host model on the open-drain bus, apb tasks for registers
// Notes: eeprom time shortened through the design parameter
module tb
  import scs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned EE_CYC = 2000;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic scl, host_low, sda_w, eip, re, a;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [7:0] b;
  logic [7:0] rb [$];
  logic [7:0] exp_b [27];
  logic [7:0] snap [27];
  logic [6:0] adr;
  scs_pad_s sda_pad;
  scs_cfg_t cfg_bytes, ee_image;
  int error_cnt, comparisons;

  // wired-and data line with pull-up
  assign sda_w = !(host_low || sda_pad.sda_oe);

  scs_smbus_slave #(.EE_PROG_CYCLES(EE_CYC)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda_w),
    .sda_pad(sda_pad), .cfg_bytes(cfg_bytes), .ee_image(ee_image),
    .eeprom_write_in_progress(eip)
  );
  scs_host_model host (.scl(scl), .sda_low(host_low), .sda(sda_w));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = !pclk;
  end

  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tx(input logic [7:0] d, input logic ea);
    host.xfer(d, 1'b1, b, a);
    chk(a, ea);
  endtask

  task automatic open_w(input logic [7:0] cmd);
    host.start();
    tx({adr, 1'b0}, 1'b0);
    tx(cmd, 1'b0);
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] n, input logic [7:0] d[$],
                    input logic blk, input logic ea);
    open_w(cmd);
    if (blk) tx(n, 1'b0);
    foreach (d[i]) tx(d[i], ea);
    host.stop();
  endtask

  task automatic rd(input logic [7:0] cmd, input int n, input logic blk);
    rb.delete();
    open_w(cmd);
    host.start();
    tx({adr, 1'b1}, 1'b0);
    if (blk) begin
      host.xfer(8'hFF, 1'b0, b, a);
      chk(b, 8'(NUM_BYTES - int'(cmd[6:0])));
    end
    for (int i = 0; i < n; i++) begin
      host.xfer(8'hFF, i == n - 1, b, a);
      rb.push_back(b);
    end
    host.stop();
  endtask

  task automatic cmp_cfg();
    for (int i = 1; i < 26; i++) chk(cfg_bytes[i], exp_b[i]);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    for (int i = 0; i < 27; i++) begin
      apb(1'b0, 12'h100 + 12'(4 * i), 32'h0);
      chk(rq, {24'h0, exp_b[i]});
    end
    apb(1'b0, 12'h200, 32'h0);
    chk(re, 1'b1);
    $display("reset test done");
  endtask

  task automatic t_single();
    wr(8'h85, 8'h00, '{8'h5A}, 1'b0, 1'b0);
    exp_b[5] = 8'h5A;
    cmp_cfg();
    rd(8'h85, 1, 1'b0);
    chk(rb[0], 8'h5A);
    rd(8'h80, 1, 1'b0);
    chk(rb[0], 8'h01);
    wr(8'h80, 8'h00, '{8'h01}, 1'b0, 1'b0);
    chk(cfg_bytes[0], 8'h00);
    $display("single test done");
  endtask

  task automatic t_block();
    wr(8'h03, 8'h04, '{8'hA1, 8'hB2, 8'hC3, 8'hD4}, 1'b1, 1'b0);
    wr(8'h07, 8'h05, '{8'h77, 8'h78}, 1'b1, 1'b0);
    exp_b[3:8] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'h77, 8'h78};
    cmp_cfg();
    rd(8'h03, 6, 1'b1);
    for (int i = 0; i < 6; i++) chk(rb[i], exp_b[3 + i]);
    rd(8'h00, 2, 1'b1);
    chk(rb[0], 8'h00);
    chk(rb[1], exp_b[1]);
    $display("block test done");
  endtask

  task automatic t_addr();
    wr(8'h8A, 8'h00, '{8'h04}, 1'b0, 1'b0);
    host.start();
    tx({adr, 1'b0}, 1'b1);
    host.stop();
    adr = 7'h6A;
    wr(8'h8A, 8'h00, '{8'h01}, 1'b0, 1'b0);
    adr = 7'h69;
    rd(8'h8A, 1, 1'b0);
    chk(rb[0], 8'h01);
    $display("address test done");
  endtask

  task automatic t_eeprom();
    snap = exp_b;
    wr(8'h9A, 8'h00, '{8'h80}, 1'b0, 1'b0);
    chk(eip, 1'b1);
    rd(8'h98, 1, 1'b0);
    chk(rb[0][7], 1'b1);
    rd(8'h03, 2, 1'b1);
    chk(rb[1], exp_b[4]);
    wr(8'h84, 8'h00, '{8'hEE}, 1'b0, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rq[0], 1'b1);
    for (int i = 0; i < 3000 && eip; i++) @(posedge pclk);
    chk(eip, 1'b0);
    for (int i = 1; i < 26; i++) chk(ee_image[i], snap[i]);
    cmp_cfg();
    apb(1'b1, 12'h000, 32'h3);
    // the request flop is set at the last apb edge; the flag rises on the next one
    repeat (2) @(posedge pclk);
    chk(eip, 1'b1);
    for (int i = 0; i < 3000 && eip; i++) @(posedge pclk);
    $display("eeprom test done");
  endtask

  initial begin
    #400us;
    error_cnt++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    adr = {5'b11010, 2'b01};
    foreach (exp_b[i]) exp_b[i] = 8'h00;
    exp_b[10] = 8'h01;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_single();
    t_block();
    t_addr();
    t_eeprom();
    end_sim();
  end
endmodule
